// ===== crpc_pkg.sv
`default_nettype none
package crpc_pkg;
  // -----------------------------------------------------------------
  // own register map (apb, one aligned word each)
  // -----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_MATCH_LO  = 8'h04;
  localparam logic [7:0] REG_MATCH_HI  = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0c;

  // ctrl fields
  localparam int CTRL_POWER_UP   = 0;
  localparam int CTRL_INIT_STATE = 1;
  localparam int CTRL_JTAG_TRST  = 2;
  localparam int CTRL_PIN_LOW    = 3;
  localparam int CTRL_STANDBY_GO = 4;
  localparam int CTRL_WAKE_EN    = 5;
  localparam int CTRL_W          = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h01;

  // status fields
  localparam int ST_CORE_GOOD  = 0;
  localparam int ST_CORE_PU    = 1;
  localparam int ST_REG_EN     = 2;
  localparam int ST_WAKE_MATCH = 3;
  localparam int ST_BUSY       = 4;
  localparam int ST_REFUSED    = 5;
  localparam int ST_STANDBY    = 6;

  // -----------------------------------------------------------------
  // device rtc register map (byte port of the device)
  // -----------------------------------------------------------------
  localparam logic [7:0] RTC_MATCH_BASE = 8'h48;
  localparam logic [7:0] RTC_CTRL_STAT  = 8'h58;
  localparam int         RTC_MATCH_BYTES = 5;
  localparam int         RTC_MATCH_W     = 40;
  localparam int         RTC_CNTR_EN     = 6;
  localparam int         RTC_WAKE_EN     = 5;
  localparam int         RTC_RSTB_CNT    = 1;
  localparam int         RTC_XTAL_EN     = 0;

  // synchronised device outputs
  localparam int SYNC_W   = 4;
  localparam int IN_CORE_GOOD = 0;
  localparam int IN_CORE_PU   = 1;
  localparam int IN_REG_EN    = 2;
  localparam int IN_WAKE      = 3;

  typedef enum logic [3:0] {
    CRPC_IDLE    = 4'b0001,
    CRPC_WRITE   = 4'b0010,
    CRPC_DROP    = 4'b0100,
    CRPC_STANDBY = 4'b1000
  } crpc_state_t;

  typedef struct packed {
    logic user_power_up_request;
    logic initial_state_tieoff;
    logic jtag_trst;
    logic power_up_pin_n_out;
    logic power_up_pin_n_oe_n;
  } crpc_pins_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } crpc_rtc_wr_t;
endpackage : crpc_pkg
`default_nettype wire

// ===== crpc_controller.sv
// What this block does
// - drive power-up request 1 to enable; 0 disables only with pin released, trst low.
// - standby only from normal operation, after enabling the rtc counter.
// - load the 40-bit match value before removing core power.
// - standby entered by driving power-up request 0; rtc keeps running.
// - set wake-match enable beforehand so a match restarts the regulator.
// - crystal enable written 1 for standby so the counter stays clocked.
`timescale 1ns/10ps
`default_nettype none
module crpc_controller (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output crpc_pkg::crpc_pins_t       pins,
  output crpc_pkg::crpc_rtc_wr_t     rtc_wr,
  input  wire logic                  core_good,
  input  wire logic                  core_power_up_out,
  input  wire logic                  regulator_enable_out,
  input  wire logic                  rtc_wake_match
);
  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  logic [crpc_pkg::SYNC_W-1:0] raw_in;
  logic [crpc_pkg::SYNC_W-1:0] sync1_r;
  logic [crpc_pkg::SYNC_W-1:0] sync2_r;
  assign raw_in = {rtc_wake_match, regulator_enable_out, core_power_up_out, core_good};

  genvar gi;
  generate
    for (gi = 0; gi < crpc_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic core_good_s;
  logic reg_en_s;
  assign core_good_s = sync2_r[crpc_pkg::IN_CORE_GOOD];
  assign reg_en_s    = sync2_r[crpc_pkg::IN_REG_EN];

  // -----------------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------------
  // one wait state so read data can leave a flip-flop
  logic                        pready_r, pready_nxt;
  logic [31:0]                 prdata_r, prdata_nxt;
  logic                        pslverr_r, pslverr_nxt;
  logic [crpc_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [crpc_pkg::RTC_MATCH_W-1:0] match_r, match_nxt;
  logic                        refused_r, refused_nxt;
  logic                        access;
  logic                        wr_hit;
  logic                        mapped;
  logic                        go;
  logic                        allowed;
  crpc_pkg::crpc_state_t       state_r, state_nxt;

  assign access = psel && penable && pready_r;
  assign mapped = (paddr == crpc_pkg::REG_CTRL) || (paddr == crpc_pkg::REG_MATCH_LO) ||
                  (paddr == crpc_pkg::REG_MATCH_HI) || (paddr == crpc_pkg::REG_STATUS);
  assign wr_hit = access && pwrite && mapped;
  assign go     = wr_hit && (paddr == crpc_pkg::REG_CTRL) && pwdata[crpc_pkg::CTRL_STANDBY_GO];
  // forced-on terms and a dark core both make standby pointless
  assign allowed = !ctrl_r[crpc_pkg::CTRL_JTAG_TRST] && !ctrl_r[crpc_pkg::CTRL_PIN_LOW] &&
                   core_good_s && reg_en_s;

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[crpc_pkg::ST_CORE_GOOD]  = core_good_s;
    status_word[crpc_pkg::ST_CORE_PU]    = sync2_r[crpc_pkg::IN_CORE_PU];
    status_word[crpc_pkg::ST_REG_EN]     = reg_en_s;
    status_word[crpc_pkg::ST_WAKE_MATCH] = sync2_r[crpc_pkg::IN_WAKE];
    status_word[crpc_pkg::ST_BUSY]       = (state_r != crpc_pkg::CRPC_IDLE);
    status_word[crpc_pkg::ST_REFUSED]    = refused_r;
    status_word[crpc_pkg::ST_STANDBY]    = (state_r == crpc_pkg::CRPC_STANDBY);
  end

  always_comb begin
    pready_nxt  = psel && penable && !pready_r;
    pslverr_nxt = psel && penable && !pready_r && !mapped;
    prdata_nxt  = prdata_r;
    if (psel && penable && !pready_r && !pwrite) begin
      case (paddr)
        crpc_pkg::REG_CTRL:     prdata_nxt = {26'h000_0000, ctrl_r};
        crpc_pkg::REG_MATCH_LO: prdata_nxt = match_r[31:0];
        crpc_pkg::REG_MATCH_HI: prdata_nxt = {24'h00_0000, match_r[39:32]};
        crpc_pkg::REG_STATUS:   prdata_nxt = status_word;
        default:                prdata_nxt = 32'h0000_0000;
      endcase
    end
    ctrl_nxt  = ctrl_r;
    match_nxt = match_r;
    if (wr_hit) begin
      case (paddr)
        crpc_pkg::REG_CTRL:     ctrl_nxt = pwdata[crpc_pkg::CTRL_W-1:0];
        crpc_pkg::REG_MATCH_LO: match_nxt[31:0] = pwdata;
        crpc_pkg::REG_MATCH_HI: match_nxt[39:32] = pwdata[7:0];
        default:                ctrl_nxt = ctrl_r;
      endcase
    end
    // go is a strobe, never stored
    ctrl_nxt[crpc_pkg::CTRL_STANDBY_GO] = 1'b0;
    refused_nxt = refused_r;
    if (wr_hit && (paddr == crpc_pkg::REG_STATUS) && pwdata[crpc_pkg::ST_REFUSED]) begin
      refused_nxt = 1'b0;
    end
    // a refusal in the clearing cycle wins
    if (go && (state_r == crpc_pkg::CRPC_IDLE) && !allowed) begin
      refused_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      ctrl_r    <= crpc_pkg::CTRL_RESET;
      match_r   <= 40'h00_0000_0000;
      refused_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
      ctrl_r    <= ctrl_nxt;
      match_r   <= match_nxt;
      refused_r <= refused_nxt;
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // -----------------------------------------------------------------
  // standby sequencer
  // -----------------------------------------------------------------
  logic [2:0]              idx_r, idx_nxt;
  crpc_pkg::crpc_rtc_wr_t  rtc_r, rtc_nxt;
  crpc_pkg::crpc_pins_t    pins_r, pins_nxt;
  logic [7:0]              rtc_ctrl_byte;

  always_comb begin
    rtc_ctrl_byte = 8'h00;
    rtc_ctrl_byte[crpc_pkg::RTC_CNTR_EN]  = 1'b1;
    rtc_ctrl_byte[crpc_pkg::RTC_RSTB_CNT] = 1'b1;
    rtc_ctrl_byte[crpc_pkg::RTC_XTAL_EN]  = 1'b1;
    rtc_ctrl_byte[crpc_pkg::RTC_WAKE_EN]  = ctrl_r[crpc_pkg::CTRL_WAKE_EN];
  end

  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    rtc_nxt   = '0;
    case (state_r)
      crpc_pkg::CRPC_IDLE: begin
        idx_nxt = 3'h0;
        if (go && allowed) begin
          state_nxt = crpc_pkg::CRPC_WRITE;
        end
      end
      crpc_pkg::CRPC_WRITE: begin
        // match bytes low first, then control/status last
        rtc_nxt.valid = 1'b1;
        if (idx_r < 3'(crpc_pkg::RTC_MATCH_BYTES)) begin
          rtc_nxt.addr = crpc_pkg::RTC_MATCH_BASE + {5'h00, idx_r};
          rtc_nxt.data = match_r[idx_r*8 +: 8];
          idx_nxt      = idx_r + 3'h1;
        end else begin
          rtc_nxt.addr = crpc_pkg::RTC_CTRL_STAT;
          rtc_nxt.data = rtc_ctrl_byte;
          state_nxt    = crpc_pkg::CRPC_DROP;
        end
      end
      crpc_pkg::CRPC_DROP: begin
        // wait until the device has really gone dark
        if (!reg_en_s) begin
          state_nxt = crpc_pkg::CRPC_STANDBY;
        end
      end
      crpc_pkg::CRPC_STANDBY: begin
        if (reg_en_s) begin
          state_nxt = crpc_pkg::CRPC_IDLE;
        end
      end
      default: state_nxt = crpc_pkg::CRPC_IDLE;
    endcase
  end

  always_comb begin
    pins_nxt = '0;
    pins_nxt.initial_state_tieoff = ctrl_r[crpc_pkg::CTRL_INIT_STATE];
    pins_nxt.jtag_trst            = ctrl_r[crpc_pkg::CTRL_JTAG_TRST];
    pins_nxt.power_up_pin_n_out   = 1'b0;
    // open drain: pull low or release to the weak pull-up
    pins_nxt.power_up_pin_n_oe_n  = !ctrl_r[crpc_pkg::CTRL_PIN_LOW];
    // request held low from the last rtc write until wake
    if ((state_nxt == crpc_pkg::CRPC_DROP) || (state_nxt == crpc_pkg::CRPC_STANDBY)) begin
      pins_nxt.user_power_up_request = 1'b0;
    end else if (state_nxt == crpc_pkg::CRPC_WRITE) begin
      pins_nxt.user_power_up_request = 1'b1;
    end else begin
      pins_nxt.user_power_up_request = ctrl_r[crpc_pkg::CTRL_POWER_UP];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= crpc_pkg::CRPC_IDLE;
      idx_r   <= 3'h0;
      rtc_r   <= '0;
      pins_r  <= '{user_power_up_request: 1'b1, initial_state_tieoff: 1'b0,
                   jtag_trst: 1'b0, power_up_pin_n_out: 1'b0, power_up_pin_n_oe_n: 1'b1};
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      rtc_r   <= rtc_nxt;
      pins_r  <= pins_nxt;
    end
  end

  assign pins   = pins_r;
  assign rtc_wr = rtc_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_forced_refuse: assert property (
    go && (state_r == crpc_pkg::CRPC_IDLE) && ctrl_r[crpc_pkg::CTRL_JTAG_TRST]
    |=> refused_r && (state_r == crpc_pkg::CRPC_IDLE))
    else $error("standby accepted while jtag out of reset");
  chk_pin_refuse: assert property (
    go && (state_r == crpc_pkg::CRPC_IDLE) && ctrl_r[crpc_pkg::CTRL_PIN_LOW]
    |=> refused_r && !pins.power_up_pin_n_oe_n)
    else $error("standby accepted while power-up pin held low");
  chk_write_burst: assert property (
    $rose(state_r == crpc_pkg::CRPC_WRITE) |=> rtc_wr.valid [*6] ##1 !rtc_wr.valid)
    else $error("rtc write burst is not six writes");
  chk_first_match: assert property (
    $rose(state_r == crpc_pkg::CRPC_WRITE)
    |=> rtc_wr.addr == crpc_pkg::RTC_MATCH_BASE && rtc_wr.data == $past(match_r[7:0]))
    else $error("first rtc write is not match byte zero");
  chk_ctrl_byte: assert property (
    rtc_wr.valid && rtc_wr.addr == crpc_pkg::RTC_CTRL_STAT
    |-> rtc_wr.data[crpc_pkg::RTC_CNTR_EN] && rtc_wr.data[crpc_pkg::RTC_XTAL_EN] &&
        rtc_wr.data[crpc_pkg::RTC_RSTB_CNT] &&
        rtc_wr.data[crpc_pkg::RTC_WAKE_EN] == $past(ctrl_r[crpc_pkg::CTRL_WAKE_EN]))
    else $error("rtc control byte wrong for standby");
  chk_request_low: assert property (
    rtc_wr.valid && rtc_wr.addr == crpc_pkg::RTC_CTRL_STAT
    |-> !pins.user_power_up_request ##1 !pins.user_power_up_request)
    else $error("power-up request not dropped after rtc setup");
  chk_wake_exit: assert property (
    (state_r == crpc_pkg::CRPC_STANDBY) && reg_en_s |=> state_r == crpc_pkg::CRPC_IDLE
    ##1 pins.user_power_up_request == $past(ctrl_r[crpc_pkg::CTRL_POWER_UP]))
    else $error("wake not followed by return to idle");
  chk_trst_drive: assert property (
    $changed(ctrl_r[crpc_pkg::CTRL_JTAG_TRST])
    |=> pins.jtag_trst == $past(ctrl_r[crpc_pkg::CTRL_JTAG_TRST]))
    else $error("jtag reset pin does not follow control");
  chk_unmapped_err: assert property (
    psel && penable && !pready && !mapped
    |=> pready && pslverr && (prdata == ($past(pwrite) ? $past(prdata) : 32'h0000_0000)))
    else $error("unmapped access not answered with error");

  cov_standby_entry: cover property (state_r == crpc_pkg::CRPC_DROP ##[1:20]
    state_r == crpc_pkg::CRPC_STANDBY);
  cov_wake: cover property (state_r == crpc_pkg::CRPC_STANDBY ##1
    state_r == crpc_pkg::CRPC_IDLE);
  cov_refused: cover property ($rose(refused_r));
endmodule : crpc_controller
`default_nettype wire

// ===== crpc_device_model.sv
`timescale 1ns/10ps
`default_nettype none
module crpc_device_model (
  input  wire logic                   pclk,
  input  wire logic                   supply_up,
  input  wire logic [39:0]            rtc_count,
  input  wire crpc_pkg::crpc_pins_t   pins,
  input  wire crpc_pkg::crpc_rtc_wr_t rtc_wr,
  output logic                        core_good,
  output logic                        core_power_up_out,
  output logic                        regulator_enable_out,
  output logic                        rtc_wake_match
);
  logic        pin_n;
  logic        init_q  = 1'b0;
  logic        wake_q  = 1'b0;
  logic [39:0] match_q = 40'h0;
  logic [7:0]  ctrl_q  = 8'h00;

  // released pin floats to its weak pull-up
  assign pin_n = pins.power_up_pin_n_oe_n ? 1'b1 : pins.power_up_pin_n_out;
  assign core_power_up_out = ~pin_n;
  assign rtc_wake_match = ctrl_q[crpc_pkg::RTC_WAKE_EN] && (rtc_count == match_q);
  assign regulator_enable_out = pins.jtag_trst | ~pin_n | pins.user_power_up_request |
                                init_q | wake_q;
  // the core is powered exactly when the regulator runs
  assign core_good = regulator_enable_out;

  always @(posedge supply_up) begin
    init_q <= pins.initial_state_tieoff;
  end

  // wake term holds until the core itself drops its request again
  always @(posedge rtc_wake_match or negedge pins.user_power_up_request) begin
    if (rtc_wake_match) begin
      wake_q <= 1'b1;
    end else begin
      wake_q <= 1'b0;
    end
  end

  always @(posedge pclk) begin
    if (rtc_wr.valid) begin
      for (int i = 0; i < crpc_pkg::RTC_MATCH_BYTES; i++) begin
        if (rtc_wr.addr == crpc_pkg::RTC_MATCH_BASE + 8'(i)) begin
          match_q[8*i +: 8] <= rtc_wr.data;
        end
      end
      if (rtc_wr.addr == crpc_pkg::RTC_CTRL_STAT) begin
        ctrl_q <= rtc_wr.data;
      end
    end
  end
endmodule : crpc_device_model
`default_nettype wire

// ===== crpc_controller_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("MISMATCH %s exp %h got %h", what, exp, got); \
    end \
  end
module crpc_controller_tb_top;
  logic                   pclk = 1'b0;
  logic                   presetn, psel, penable, pwrite, pready, pslverr, supply_up;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, q;
  logic                   e;
  logic [39:0]            rtc_count;
  crpc_pkg::crpc_pins_t   pins;
  crpc_pkg::crpc_rtc_wr_t rtc_wr;
  logic                   core_good, core_power_up_out, regulator_enable_out, rtc_wake_match;
  int                     miscompares = 0;
  int                     compares    = 0;

  always #4 pclk = ~pclk;

  crpc_controller DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .rtc_wr(rtc_wr), .core_good(core_good),
    .core_power_up_out(core_power_up_out), .regulator_enable_out(regulator_enable_out),
    .rtc_wake_match(rtc_wake_match));

  crpc_device_model DEV (.pclk(pclk), .supply_up(supply_up), .rtc_count(rtc_count),
    .pins(pins), .rtc_wr(rtc_wr), .core_good(core_good),
    .core_power_up_out(core_power_up_out), .regulator_enable_out(regulator_enable_out),
    .rtc_wake_match(rtc_wake_match));

  // -----------------------------------------------------------------
  // apb master
  // -----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      xfer(1'b0, crpc_pkg::REG_STATUS, 32'h0, q, e);
      n++;
    end while (q[b] !== v && n < 100);
    if (q[b] !== v) begin
      miscompares++;
      $display("MISMATCH status bit %0d exp %b got %b", b, v, q[b]);
    end
  endtask : wait_st

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    summarize();
  end

  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    supply_up = 1'b0;
    rtc_count = 40'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    supply_up <= 1'b1;
    `CHK("pins", 5'h11, pins);
    xfer(1'b0, crpc_pkg::REG_CTRL, 32'h0, q, e);
    `CHK("ctrl", crpc_pkg::CTRL_RESET, q[5:0]);
    xfer(1'b0, crpc_pkg::REG_STATUS, 32'h0, q, e);
    `CHK("status", 7'h05, q[6:0]);
    xfer(1'b0, 8'h10, 32'h0, q, e);
    `CHK("slverr rd", 1'b1, e);
    xfer(1'b1, 8'h10, 32'h3f, q, e);
    `CHK("slverr wr", 1'b1, e);
    // pin pulled low, request off, go must be refused
    // the refusal looks at the stored control, so the pin goes low first
    wr(crpc_pkg::REG_CTRL, 32'h08);
    wr(crpc_pkg::REG_CTRL, 32'h18);
    repeat (4) @(posedge pclk);
    `CHK("core pu", 1'b1, core_power_up_out);
    `CHK("reg en", 1'b1, regulator_enable_out);
    xfer(1'b0, crpc_pkg::REG_STATUS, 32'h0, q, e);
    `CHK("status pin", 7'h27, q[6:0]);
    wr(crpc_pkg::REG_STATUS, 32'h20);
    xfer(1'b0, crpc_pkg::REG_STATUS, 32'h0, q, e);
    `CHK("refused clr", 1'b0, q[5]);
    wr(crpc_pkg::REG_CTRL, 32'h04);
    wr(crpc_pkg::REG_CTRL, 32'h14);
    repeat (4) @(posedge pclk);
    `CHK("reg en trst", 1'b1, regulator_enable_out);
    xfer(1'b0, crpc_pkg::REG_STATUS, 32'h0, q, e);
    `CHK("status trst", 7'h25, q[6:0]);
    wr(crpc_pkg::REG_STATUS, 32'h20);
    wr(crpc_pkg::REG_CTRL, 32'h01);
    // standby with wake on match
    wr(crpc_pkg::REG_MATCH_LO, 32'h44332211);
    wr(crpc_pkg::REG_MATCH_HI, 32'h00000055);
    wr(crpc_pkg::REG_CTRL, 32'h31);
    wait_st(6, 1'b1);
    `CHK("match", 40'h5544332211, DEV.match_q);
    `CHK("rtc ctrl", 8'h63, DEV.ctrl_q);
    `CHK("reg off", 1'b0, regulator_enable_out);
    `CHK("req off", 1'b0, pins.user_power_up_request);
    @(posedge pclk);
    rtc_count <= 40'h5544332211;
    wait_st(4, 1'b0);
    `CHK("wake", 1'b1, rtc_wake_match);
    xfer(1'b0, crpc_pkg::REG_STATUS, 32'h0, q, e);
    `CHK("status wake", 7'h0d, q[6:0]);
    `CHK("req on", 1'b1, pins.user_power_up_request);
    rtc_count <= 40'h0;
    // standby without wake enable: match is masked, pin brings it back
    wr(crpc_pkg::REG_CTRL, 32'h11);
    wait_st(6, 1'b1);
    @(posedge pclk);
    rtc_count <= 40'h5544332211;
    repeat (10) @(posedge pclk);
    `CHK("no wake", 1'b0, rtc_wake_match);
    `CHK("still off", 1'b0, regulator_enable_out);
    wr(crpc_pkg::REG_CTRL, 32'h09);
    wait_st(4, 1'b0);
    `CHK("pin wake", 1'b1, regulator_enable_out);
    wr(crpc_pkg::REG_CTRL, 32'h03);
    rtc_count <= 40'h0;
    // let the tie-off reach the pin before the supply edge samples it
    @(posedge pclk);
    supply_up <= 1'b0;
    @(posedge pclk);
    supply_up <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("init pin", 1'b1, pins.initial_state_tieoff);
    `CHK("init latch", 1'b1, DEV.init_q);
    summarize();
  end
endmodule : crpc_controller_tb_top
`undef CHK
`default_nettype wire
